//--- src/stl_pkg.sv
// constants for the skip-test and timer-load execution block
package stl_pkg;
    // 10-bit instruction codes
    localparam logic [9:0] OP_SKIP_MEM_BIT_BASE = 10'h020;
    localparam logic [9:0] OP_SKIP_MEM_BIT_MASK = 10'h3FC;
    localparam logic [9:0] OP_SKIP_CARRY = 10'h02F;
    localparam logic [9:0] OP_SKIP_PORT_W1 = 10'h024;
    localparam logic [9:0] OP_SKIP_PORT_W2 = 10'h02B;
    localparam logic [9:0] OP_LOAD_TIMER1 = 10'h230;
    // field positions
    localparam int BIT_SEL_LSB = 0;
    localparam int BIT_SEL_W = 2;
    localparam int PIN_SEL_W = 3;
    // reset values
    localparam logic [7:0] TIMER1_RST = 8'h00;
    typedef enum logic [1:0] {STL_IDLE, STL_PORT_W2, STL_SKIP} stl_state_t;
endpackage

//--- src/stl_exec.sv
// execution of the skip tests and the timer-1 load instruction
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// [RL1] memory bit zero skips next instruction
// [RL2] memory bit one executes next; one cycle
// [RL3] carry zero skips, carry unchanged; one cycle
// [RL4] port D bit by Y zero skips
// [RL5] port bit one executes; two words, cycles
// [RL6] B loads upper nibble of timer, reload
// [RL7] A loads lower nibble, same cycle
// [RL8] skipped instruction fetched but acts as nop
////////////////////////////////////////////////////////////////////////////////
module stl_exec (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // instruction stream, one word per cycle
    input wire logic [9:0] instr_in,
    // core state
    input wire logic [3:0] mem_data_in,
    input wire logic carry_flag_in,
    input wire logic [3:0] acc_in,
    input wire logic [3:0] reg_b_in,
    input wire logic [2:0] reg_y_in,
    input wire logic [7:0] port_d_in,
    // outputs
    output logic skip_active_out,
    output logic exec_enable_out,
    output logic [7:0] timer1_count_out,
    output logic [7:0] timer1_reload_reg_out,
    output logic timer1_load_out,
    output logic carry_flag_out
);
    import stl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // decoders shared by the state logic and the timer path
    function automatic logic is_mem_bit_op(input logic [9:0] op);
        is_mem_bit_op = (op & OP_SKIP_MEM_BIT_MASK) == OP_SKIP_MEM_BIT_BASE;
    endfunction

    function automatic logic is_carry_op(input logic [9:0] op);
        is_carry_op = (op == OP_SKIP_CARRY);
    endfunction

    function automatic logic is_port_first(input logic [9:0] op);
        is_port_first = (op == OP_SKIP_PORT_W1);
    endfunction

    function automatic logic is_timer_load(input logic [9:0] op);
        is_timer_load = (op == OP_LOAD_TIMER1);
    endfunction

    // zero test of one nibble bit, the skip sense of the memory test
    function automatic logic bit_is_zero(input logic [3:0] nib, input logic [1:0] sel);
        bit_is_zero = ~nib[sel];
    endfunction

    // zero test of one synchronised pin, the skip sense of the port test
    function automatic logic pin_is_zero(input logic [7:0] pins, input logic [2:0] sel);
        pin_is_zero = ~pins[sel];
    endfunction

    stl_state_t state_ff;
    stl_state_t nxt_state;
    logic [7:0] port_s1_ff;
    logic [7:0] port_s2_ff;
    logic [7:0] port_s3_ff;
    logic [7:0] port_ff;
    logic skip_cond;
    logic executing;
    logic [BIT_SEL_W-1:0] bit_sel;
    logic load_now;
    logic [3:0] timer1_hi_ff;
    logic [3:0] timer1_lo_ff;
    logic [3:0] reload_hi_ff;
    logic [3:0] reload_lo_ff;
    logic load_strobe_ff;

    ////////////////////////////////////////////////////////////////////////////
    // port D pins: three stages, accept when the last two agree
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            port_s1_ff <= 8'h00;
            port_s2_ff <= 8'h00;
            port_s3_ff <= 8'h00;
            port_ff <= 8'h00;
        end else begin
            port_s1_ff <= port_d_in;
            port_s2_ff <= port_s1_ff;
            port_s3_ff <= port_s2_ff;
            for (int i = 0; i < 8; i++) begin
                if (port_s2_ff[i] == port_s3_ff[i]) begin
                    port_ff[i] <= port_s3_ff[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // a word in the skip slot never executes, so it cannot start a test
    assign executing = (state_ff == STL_IDLE);
    assign bit_sel = instr_in[BIT_SEL_LSB +: BIT_SEL_W];
    // a load in the skip slot or as a port second word must not land
    assign load_now = executing && is_timer_load(instr_in);

    always_comb begin
        nxt_state = STL_IDLE;
        skip_cond = 1'b0;
        unique case (state_ff)
            STL_IDLE: begin
                // [RL1] memory bit zero
                if (is_mem_bit_op(instr_in)) begin
                    skip_cond = bit_is_zero(mem_data_in, bit_sel);
                // [RL3] carry zero test
                end else if (is_carry_op(instr_in)) begin
                    skip_cond = ~carry_flag_in;
                end
                // [RL4] port test first word
                if (is_port_first(instr_in)) begin
                    nxt_state = STL_PORT_W2;
                end else if (skip_cond) begin
                    nxt_state = STL_SKIP;
                end
            end
            STL_PORT_W2: begin
                // [RL5] second word resolves test
                skip_cond = pin_is_zero(port_ff, reg_y_in[PIN_SEL_W-1:0]);
                nxt_state = skip_cond ? STL_SKIP : STL_IDLE;
            end
            STL_SKIP: begin
                // [RL8] slot consumed as nop
                nxt_state = STL_IDLE;
            end
            default: nxt_state = STL_IDLE;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            state_ff <= STL_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // [RL8] suppress effects of the skipped word
    // registered so the core sees a clean flag for the whole slot
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            skip_active_out <= 1'b0;
        end else begin
            skip_active_out <= (nxt_state == STL_SKIP);
        end
    end

    // [RL8] enable low across skip slot
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            exec_enable_out <= 1'b1;
        end else begin
            exec_enable_out <= (nxt_state != STL_SKIP);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // [RL6] B into timer upper nibble
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            timer1_hi_ff <= TIMER1_RST[7:4];
        end else if (load_now) begin
            timer1_hi_ff <= reg_b_in;
        end
    end

    // [RL6] B into reload upper nibble
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            reload_hi_ff <= TIMER1_RST[7:4];
        end else if (load_now) begin
            reload_hi_ff <= reg_b_in;
        end
    end

    // [RL7] A into timer lower nibble
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            timer1_lo_ff <= TIMER1_RST[3:0];
        end else if (load_now) begin
            timer1_lo_ff <= acc_in;
        end
    end

    // [RL7] A into reload lower nibble
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            reload_lo_ff <= TIMER1_RST[3:0];
        end else if (load_now) begin
            reload_lo_ff <= acc_in;
        end
    end

    // one-cycle strobe; the timer counter itself lives elsewhere
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            load_strobe_ff <= 1'b0;
        end else begin
            load_strobe_ff <= load_now;
        end
    end

    // all four nibbles share one enable, so both halves land in one cycle
    assign timer1_count_out = {timer1_hi_ff, timer1_lo_ff};
    assign timer1_reload_reg_out = {reload_hi_ff, reload_lo_ff};
    assign timer1_load_out = load_strobe_ff;

    ////////////////////////////////////////////////////////////////////////////
    // [RL3] carry passes through untouched
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            carry_flag_out <= 1'b0;
        end else begin
            carry_flag_out <= carry_flag_in;
        end
    end
endmodule

//--- testbench/stl_exec_asserts.sv
// checker for the skip-test and timer-load block
`timescale 1ns/10ps
module stl_exec_chk (
    input wire logic clock_in, rst_n_in, carry_flag_in, skip_active_out, exec_enable_out,
    input wire logic timer1_load_out, carry_flag_out,
    input wire logic [9:0] instr_in,
    input wire logic [3:0] mem_data_in, acc_in, reg_b_in,
    input wire logic [2:0] reg_y_in,
    input wire logic [7:0] port_d_in, timer1_count_out, timer1_reload_reg_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    // skip-slot words are ignored, so mb, ld and pw arm only on words with exec_enable_out high
    wire mb = instr_in[9:2] == 8'h08 && exec_enable_out;
    wire ld = instr_in == 10'h230 && exec_enable_out;
    wire pw = instr_in == 10'h024 && exec_enable_out;
    chk_mem_zero_skip: assert property (mb && !mem_data_in[instr_in[1:0]] |=> skip_active_out)
        else $error("bit zero not skipped");
    chk_mem_one_run: assert property (mb && mem_data_in[instr_in[1:0]] |=> !skip_active_out)
        else $error("bit one skipped");
    chk_carry_skip: assert property (instr_in == 10'h02F && exec_enable_out |=>
        skip_active_out != $past(carry_flag_in) && carry_flag_out == $past(carry_flag_in))
        else $error("carry test wrong");
    chk_port_skip: assert property (pw ##1 instr_in == 10'h02B |=>
        skip_active_out == !port_d_in[$past(reg_y_in)])
        else $error("port test wrong");
    chk_port_two_words: assert property (pw |=> exec_enable_out)
        else $error("second word skipped");
    chk_load_upper: assert property (ld |=> timer1_load_out && timer1_count_out[7:4] ==
        $past(reg_b_in) && timer1_reload_reg_out[7:4] == $past(reg_b_in))
        else $error("upper nibble wrong");
    chk_load_lower: assert property (ld |=> timer1_count_out[3:0] == $past(acc_in) &&
        timer1_reload_reg_out[3:0] == $past(acc_in))
        else $error("lower nibble wrong");
    chk_skipped_nop: assert property (skip_active_out |-> !exec_enable_out ##1
        !timer1_load_out && $stable(timer1_count_out))
        else $error("skipped word acted");
    cover property (skip_active_out);
    cover property (timer1_load_out);
    cover property (pw ##1 instr_in == 10'h02B ##1 skip_active_out);
endmodule
bind stl_exec stl_exec_chk stl_exec_chk_i (.*);

//--- testbench/stl_exec_tb_top.sv
// testbench for the skip-test and timer-load block
`timescale 1ns/10ps
module stl_exec_tb_top;
    logic clock_in = 0, rst_n_in = 0, carry_flag_in = 0;
    logic [9:0] instr_in = 10'h000;
    logic [3:0] mem_data_in = 4'h0, acc_in = 4'h0, reg_b_in = 4'h0;
    logic [2:0] reg_y_in = 3'h0;
    // port pins set at time zero; reset holds the synchroniser at zero, so it settles during t_mem, before t_port
    logic [7:0] port_d_in = 8'hA5;
    logic skip_active_out, exec_enable_out, timer1_load_out, carry_flag_out;
    logic [7:0] timer1_count_out, timer1_reload_reg_out;
    int miscompares = 0, n_tests = 0;
    always #20 clock_in = ~clock_in;
    stl_exec stl_exec_i (.*);
    task chk(input logic [7:0] s, input logic [7:0] e);
        n_tests++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task issue(input logic [9:0] w);
        @(posedge clock_in);
        #1 instr_in = w;
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task t_mem;
        for (int j = 0; j < 8; j++) begin
            mem_data_in = j[2] ? 4'hA : 4'h5;
            issue({8'h08, 2'(j)});
            issue(10'h000);
            chk(skip_active_out, !mem_data_in[j[1:0]]);
        end
    endtask
    task t_carry;
        for (int c = 0; c < 2; c++) begin
            carry_flag_in = c[0];
            issue(10'h02F);
            issue(10'h000);
            chk(skip_active_out, !c[0]);
            chk(exec_enable_out, c[0]);
            chk(carry_flag_out, c[0]);
        end
    endtask
    task t_port;
        for (int y = 0; y < 8; y++) begin
            reg_y_in = 3'(y);
            issue(10'h024);
            issue(10'h02B);
            chk(exec_enable_out, 1'b1);
            issue(10'h000);
            chk(skip_active_out, !port_d_in[y]);
        end
    endtask
    task t_load;
        acc_in = 4'h5;
        reg_b_in = 4'h3;
        issue(10'h230);
        issue(10'h000);
        chk(timer1_count_out, 8'h35);
        chk(timer1_reload_reg_out, 8'h35);
        chk(timer1_load_out, 1'b1);
        carry_flag_in = 1'b0;
        issue(10'h02F);
        acc_in = 4'h9;
        reg_b_in = 4'hC;
        issue(10'h230);
        issue(10'h000);
        chk(timer1_load_out, 1'b0);
        chk(timer1_count_out, 8'h35);
    endtask
    initial begin
        repeat (12) @(posedge clock_in);
        #1 rst_n_in = 1;
        t_mem;
        t_carry;
        t_port;
        t_load;
        give_verdict;
    end
endmodule
